// >>> core/flash_cmd_dev.sv
// Behaviour
// - Resume is D0h alone; extra bytes ignored
// - Valid resume restarts suspended operation promptly
// - Resume clears paused flag, reports busy
// - Resume needs whole opcode, byte-aligned release
// - Resume works regardless of write latch
// - Both paused: program resumes first
// - Suspend ignored while resume still settling
// - Host waits latency or polls before suspending
// - Write enable 06h sets write latch; here ignored while a program is paused
// - Guarded commands need write latch set
// - Bad enable/disable framing leaves latch alone
// - Write disable 04h clears write latch; here ignored while a program is paused
// - One guard bit per sector, reset protected
// - Guard 0 allows, 1 rejects program/erase
// - Protect 36h plus address sets guard
// - Short protect: guard kept, latch cleared
// - Unprotect 39h plus address clears guard
// - Short unprotect: guard kept, latch cleared
// - Locked guards: ignore, clear latch, idle
// - Host enables writes before each guard change
// - Suspend B0h pauses running operation
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
module flash_cmd_dev
  import flash_cmd_pkg::*;
#(
  parameter int RES_CYCLES = RES_CYCLES_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  flash_link_if.dev link,
  // Array engine status
  input wire logic prog_running,
  input wire logic erase_running,
  input wire logic protect_regs_locked_flag,
  // Program or erase admission check
  input wire logic pe_req,
  input wire logic pe_is_erase,
  input wire logic [ADDR_W-1:0] pe_addr,
  output logic pe_grant,
  output logic pe_deny,
  // Engine controls, one-cycle pulses
  output logic resume_prog,
  output logic resume_erase,
  output logic suspend_prog,
  output logic suspend_erase,
  // Status flags
  output logic write_latch_flag,
  output logic program_paused_flag,
  output logic erase_paused_flag,
  output logic ready_busy_flag,
  output logic [N_SECTORS-1:0] sector_write_guard_bit
);
  typedef struct packed {
    logic cs_prev;
    logic sck_prev;
    logic [7:0] sr;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic wel;
    logic pp;
    logic ep;
    logic busy;
    logic [N_SECTORS-1:0] guard;
    logic [CNT_W-1:0] res_cnt;
    logic res_p;
    logic res_e;
    logic sus_p;
    logic sus_e;
    logic grant;
    logic deny;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{
    cs_prev: 1'b1,
    guard: GUARD_RESET,
    default: '0
  };

  dev_state_t s_q;
  dev_state_t s_d;
  logic cs_n_s;
  logic sck_s;
  logic mosi_s;

  // Idle cs high, sck low, mosi low
  link_sync #(
    .W(3),
    .RST(3'h4)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({link.cs_n, link.sck, link.mosi}),
    .dout({cs_n_s, sck_s, mosi_s})
  );

  always_comb begin
    logic [7:0] byte_v;
    logic aligned;
    logic have_op;
    logic full_addr;
    logic suspended;
    byte_v = {s_q.sr[6:0], mosi_s};
    aligned = (s_q.bit_cnt == '0);
    have_op = (s_q.byte_cnt != '0);
    full_addr = (s_q.byte_cnt > ADDR_BYTES);
    suspended = s_q.pp | s_q.ep;

    s_d = s_q;
    s_d.res_p = 1'b0;
    s_d.res_e = 1'b0;
    s_d.sus_p = 1'b0;
    s_d.sus_e = 1'b0;
    s_d.grant = 1'b0;
    s_d.deny = 1'b0;
    s_d.cs_prev = cs_n_s;
    s_d.sck_prev = sck_s;
    if (s_q.res_cnt != '0) begin
      s_d.res_cnt = s_q.res_cnt - 1'b1;
    end

    // Admission check; a latch set on the same edge wins below
    if (pe_req) begin
      s_d.wel = 1'b0;
      if (!s_q.wel) begin
        s_d.deny = 1'b1;
      end else if (s_q.guard[sector_of(pe_addr)]) begin
        s_d.deny = 1'b1;
      end else if (pe_is_erase ? suspended : s_q.pp) begin
        s_d.deny = 1'b1;
      end else begin
        s_d.grant = 1'b1;
      end
    end

    if (!cs_n_s && s_q.cs_prev) begin
      s_d.bit_cnt = '0;
      s_d.byte_cnt = '0;
    end else if (!cs_n_s && sck_s && !s_q.sck_prev) begin
      // Shift in MSB first on rising sck
      s_d.sr = byte_v;
      s_d.bit_cnt = s_q.bit_cnt + 3'h1;
      if (s_q.bit_cnt == BIT_LAST) begin
        if (!have_op) begin
          s_d.opcode = byte_v;
        end else if (!full_addr) begin
          s_d.addr = {s_q.addr[ADDR_W-9:0], byte_v};
        end
        // Trailing bytes only advance a saturating count
        if (s_q.byte_cnt != BYTE_CNT_MAX) begin
          s_d.byte_cnt = s_q.byte_cnt + 3'h1;
        end
      end
    end else if (cs_n_s && !s_q.cs_prev && have_op) begin
      case (s_q.opcode)
        OP_RESUME: begin
          // No latch check here
          if (aligned) begin
            if (s_q.pp) begin
              s_d.pp = 1'b0;
              s_d.res_p = 1'b1;
              s_d.res_cnt = CNT_W'(RES_CYCLES);
            end else if (s_q.ep) begin
              s_d.ep = 1'b0;
              s_d.res_e = 1'b1;
              s_d.res_cnt = CNT_W'(RES_CYCLES);
            end
          end
        end
        OP_SUSPEND: begin
          // Settling resume cannot be paused again
          if (aligned && s_q.res_cnt == '0) begin
            if (prog_running && !s_q.pp) begin
              s_d.pp = 1'b1;
              s_d.sus_p = 1'b1;
            end else if (erase_running && !s_q.ep) begin
              s_d.ep = 1'b1;
              s_d.sus_e = 1'b1;
            end
          end
        end
        OP_WREN: begin
          if (aligned && !s_q.pp) begin
            s_d.wel = 1'b1;
          end
        end
        OP_WRDI: begin
          if (aligned && !s_q.pp) begin
            s_d.wel = 1'b0;
          end
        end
        OP_PROTECT, OP_UNPROTECT: begin
          // Refused outright while anything is paused
          if (!suspended && s_q.wel) begin
            s_d.wel = 1'b0;
            if (aligned && full_addr &&
                !protect_regs_locked_flag) begin
              s_d.guard[sector_of(s_q.addr)] =
                (s_q.opcode == OP_PROTECT);
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Busy while settling or while the engine works
    s_d.busy = prog_running | erase_running |
               (s_d.res_cnt != '0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= DEV_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign pe_grant = s_q.grant;
  assign pe_deny = s_q.deny;
  assign resume_prog = s_q.res_p;
  assign resume_erase = s_q.res_e;
  assign suspend_prog = s_q.sus_p;
  assign suspend_erase = s_q.sus_e;
  assign write_latch_flag = s_q.wel;
  assign program_paused_flag = s_q.pp;
  assign erase_paused_flag = s_q.ep;
  assign ready_busy_flag = s_q.busy;
  assign sector_write_guard_bit = s_q.guard;
endmodule : flash_cmd_dev

// >>> core/flash_cmd_host.sv
module flash_cmd_host
  import flash_cmd_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial link
  flash_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_END, H_GAP} host_st_t;

  typedef struct packed {
    host_st_t st;
    logic [7:0] div;
    logic [5:0] bits_left;
    logic [63:0] sr;
    logic [31:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic cs_n;
    logic sck;
    logic mosi;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [3:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } host_state_t;

  localparam host_state_t HOST_RESET = '{
    st: H_IDLE,
    cs_n: 1'b1,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };
  localparam logic [7:0] HALF = 8'(SCK_HALF - 1);

  host_state_t s_q;
  host_state_t s_d;

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    logic busy;
    logic [31:0] c;
    logic [5:0] total;
    logic [31:0] a;
    busy = (s_q.st != H_IDLE);
    c = merge(s_q.cmd, s_q.wd, s_q.ws);
    a = merge({8'h0, s_q.addr}, s_q.wd, s_q.ws);
    total = 6'({c[CMD_NB_LSB +: 3], 3'h0}) + 6'(c[CMD_XB_LSB +: 3]);
    s_d = s_q;

    if (awvalid && s_q.awready) begin
      s_d.awready = 1'b0;
      s_d.wa = awaddr[3:0];
    end
    if (wvalid && s_q.wready) begin
      s_d.wready = 1'b0;
      s_d.wd = wdata;
      s_d.ws = wstrb;
    end
    if (bvalid && bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end else if (!s_q.awready && !s_q.wready && !s_q.bvalid) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = AXI_OKAY;
      if (s_q.wa == REG_CMD) begin
        s_d.cmd = c;
        // A command written mid-frame is stored, not started
        if (!busy) begin
          s_d.sr = {c[CMD_OP_LSB +: 8], s_q.addr, 32'h0};
          s_d.bits_left = total;
          s_d.cs_n = 1'b0;
          s_d.mosi = c[CMD_OP_LSB + 7];
          s_d.div = HALF;
          s_d.st = (total != '0) ? H_LOW : H_END;
        end
      end else if (s_q.wa == REG_ADDR) begin
        s_d.addr = a[ADDR_W-1:0];
      end else if (s_q.wa != REG_STATUS) begin
        s_d.bresp = AXI_SLVERR;
      end
    end

    if (rvalid && rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end else if (arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = AXI_OKAY;
      s_d.rdata = '0;
      if (araddr[3:0] == REG_CMD) begin
        s_d.rdata = s_q.cmd;
      end else if (araddr[3:0] == REG_ADDR) begin
        s_d.rdata = {8'h0, s_q.addr};
      end else if (araddr[3:0] == REG_STATUS) begin
        s_d.rdata[STAT_BUSY_BIT] = busy;
      end else begin
        s_d.rresp = AXI_SLVERR;
      end
    end

    // Mode 0: data moves on falling sck, device samples rising
    if (busy && s_q.div != '0) begin
      s_d.div = s_q.div - 8'h1;
    end else if (busy) begin
      s_d.div = HALF;
      case (s_q.st)
        H_LOW: begin
          s_d.sck = 1'b1;
          s_d.st = H_HIGH;
        end
        H_HIGH: begin
          s_d.sck = 1'b0;
          s_d.sr = {s_q.sr[62:0], 1'b0};
          s_d.mosi = s_q.sr[62];
          s_d.bits_left = s_q.bits_left - 6'h1;
          s_d.st = (s_q.bits_left == 6'h1) ? H_END : H_LOW;
        end
        H_END: begin
          s_d.cs_n = 1'b1;
          s_d.mosi = 1'b0;
          s_d.st = H_GAP;
        end
        default: begin
          s_d.st = H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= HOST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rresp = s_q.rresp;
  assign rdata = s_q.rdata;
  assign link.cs_n = s_q.cs_n;
  assign link.sck = s_q.sck;
  assign link.mosi = s_q.mosi;
endmodule : flash_cmd_host

// >>> core/flash_cmd_pkg.sv
package flash_cmd_pkg;
  // Opcodes
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PROTECT = 8'h36;
  localparam logic [7:0] OP_UNPROTECT = 8'h39;

  // Addressing and sectors (64 kB each)
  localparam int ADDR_W = 24;
  localparam int ADDR_BYTES = 3;
  localparam int SECTOR_LSB = 16;
  localparam int N_SECTORS = 16;
  localparam int SECTOR_W = 4;
  localparam logic [N_SECTORS-1:0] GUARD_RESET = 16'hFFFF;

  // Byte framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;

  // Timing
  localparam int CLK_NS = 50;
  localparam int RESUME_LATENCY_NS = 1000;
  localparam int RES_CYCLES_DEF =
    (RESUME_LATENCY_NS / CLK_NS) < 1 ? 1 : (RESUME_LATENCY_NS / CLK_NS);
  localparam int CNT_W = 16;
  localparam int SCK_HALF_DEF = 4;

  // Host register map and fields
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_NB_LSB = 8;
  localparam int CMD_XB_LSB = 12;
  localparam int STAT_BUSY_BIT = 0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  function automatic logic [SECTOR_W-1:0] sector_of(
    input logic [ADDR_W-1:0] a);
    return a[SECTOR_LSB +: SECTOR_W];
  endfunction : sector_of
endpackage : flash_cmd_pkg

// >>> core/flash_link_if.sv
interface flash_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  modport dev (input cs_n, input sck, input mosi);
  modport host (output cs_n, output sck, output mosi);
endinterface : flash_link_if

// >>> core/link_sync.sv
module link_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  always_comb begin
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= {RST, RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;
endmodule : link_sync

// >>> test/flash_resume_wel_sector_protect_props.sv
module flash_resume_wel_sector_protect_props
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  // Device side
  input wire logic protect_regs_locked_flag,
  input wire logic pe_req,
  input wire logic [ADDR_W-1:0] pe_addr,
  input wire logic pe_grant,
  input wire logic pe_deny,
  input wire logic resume_prog,
  input wire logic resume_erase,
  input wire logic suspend_prog,
  input wire logic suspend_erase,
  input wire logic write_latch_flag,
  input wire logic program_paused_flag,
  input wire logic ready_busy_flag,
  input wire logic [N_SECTORS-1:0] sector_write_guard_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Recent chip-select releases; device answers a few cycles later
  logic cs_q;
  logic [5:0] rise_q;
  always_ff @(posedge aclk) begin
    cs_q <= cs_n;
    rise_q <= {rise_q[4:0], cs_n & ~cs_q};
  end

  chk_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("serial clock moved outside a frame");
  chk_mosi_held: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("data changed while serial clock high");
  chk_latch_set: assert property ($rose(write_latch_flag) |-> |rise_q)
    else $error("write latch set without a frame");
  chk_latch_clear: assert property ($fell(write_latch_flag) |->
    (|rise_q) || $past(pe_req))
    else $error("write latch cleared without cause");
  chk_guard_cause: assert property (!$stable(sector_write_guard_bit) |->
    (|rise_q) && $past(write_latch_flag) && !protect_regs_locked_flag)
    else $error("guard bits changed without enabled frame");
  chk_grant_once: assert property (pe_req |=> pe_grant != pe_deny)
    else $error("admission gave no single answer");
  chk_guard_deny: assert property (pe_req &&
    sector_write_guard_bit[pe_addr[SECTOR_LSB +: SECTOR_W]] |=> pe_deny)
    else $error("protected sector admitted");
  chk_latch_deny: assert property (pe_req && !write_latch_flag |=> pe_deny)
    else $error("admitted without write latch");
  chk_resume_flag: assert property (resume_prog |->
    !program_paused_flag && $past(program_paused_flag))
    else $error("program resume without paused flag clearing");
  chk_prog_first: assert property (resume_erase |->
    !$past(program_paused_flag))
    else $error("erase resumed before paused program");
  chk_resume_busy: assert property (resume_prog || resume_erase |=>
    (ready_busy_flag && !suspend_prog && !suspend_erase) [*2])
    else $error("not busy or suspended right after resume");
  chk_suspend_flag: assert property (suspend_prog |->
    program_paused_flag && !$past(program_paused_flag))
    else $error("program suspend without paused flag setting");
endmodule : flash_resume_wel_sector_protect_props

// >>> test/flash_resume_wel_sector_protect_test.sv
module flash_resume_wel_sector_protect_test
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] op;
    logic [2:0] nb;
    logic [2:0] xb;
    logic [23:0] ad;
    logic lk;
    logic wl;
    logic [15:0] g;
  } row_t;
  // Opcode, bytes, extra bits, address, lock, latch and guards after
  row_t rows[17] = '{
    '{8'h06, 3'h1, 3'h0, 24'h000000, 1'b0, 1'b1, 16'hFFFF},
    '{8'h04, 3'h1, 3'h0, 24'h000000, 1'b0, 1'b0, 16'hFFFF},
    '{8'h06, 3'h1, 3'h3, 24'h000000, 1'b0, 1'b0, 16'hFFFF},
    '{8'h06, 3'h2, 3'h0, 24'h000000, 1'b0, 1'b1, 16'hFFFF},
    '{8'h04, 3'h1, 3'h5, 24'h000000, 1'b0, 1'b1, 16'hFFFF},
    '{8'h39, 3'h4, 3'h0, 24'h030000, 1'b0, 1'b0, 16'hFFF7},
    '{8'h39, 3'h4, 3'h0, 24'h050000, 1'b0, 1'b0, 16'hFFF7},
    '{8'h06, 3'h1, 3'h0, 24'h000000, 1'b0, 1'b1, 16'hFFF7},
    '{8'h39, 3'h3, 3'h0, 24'h050000, 1'b0, 1'b0, 16'hFFF7},
    '{8'h06, 3'h1, 3'h0, 24'h000000, 1'b0, 1'b1, 16'hFFF7},
    '{8'h39, 3'h5, 3'h0, 24'h05ABCD, 1'b0, 1'b0, 16'hFFD7},
    '{8'h06, 3'h1, 3'h0, 24'h000000, 1'b0, 1'b1, 16'hFFD7},
    '{8'h36, 3'h4, 3'h2, 24'h030000, 1'b0, 1'b0, 16'hFFD7},
    '{8'h06, 3'h1, 3'h0, 24'h000000, 1'b0, 1'b1, 16'hFFD7},
    '{8'h36, 3'h4, 3'h0, 24'h03FFFF, 1'b0, 1'b0, 16'hFFDF},
    '{8'h06, 3'h1, 3'h0, 24'h000000, 1'b0, 1'b1, 16'hFFDF},
    '{8'h39, 3'h4, 3'h0, 24'h000000, 1'b1, 1'b0, 16'hFFDF}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  logic prog_running = 1'b0, erase_running = 1'b0;
  logic protect_regs_locked_flag = 1'b0, pe_req = 1'b0, pe_is_erase = 1'b0;
  logic [23:0] pe_addr = 24'h0;
  logic pe_grant, pe_deny, resume_prog, resume_erase;
  logic suspend_prog, suspend_erase, write_latch_flag;
  logic program_paused_flag, erase_paused_flag, ready_busy_flag;
  logic [15:0] sector_write_guard_bit;
  int mismatches = 0, checked = 0, cycles = 0;

  flash_link_if link();
  flash_cmd_host i_flash_cmd_host (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .link(link));
  // Long resume hold so a suspend can land inside it
  flash_cmd_dev #(.RES_CYCLES(400)) i_flash_cmd_dev (.aclk, .aresetn,
    .link(link), .prog_running, .erase_running, .protect_regs_locked_flag,
    .pe_req, .pe_is_erase, .pe_addr, .pe_grant, .pe_deny, .resume_prog,
    .resume_erase, .suspend_prog, .suspend_erase, .write_latch_flag,
    .program_paused_flag, .erase_paused_flag, .ready_busy_flag,
    .sector_write_guard_bit);
  flash_resume_wel_sector_protect_props
    i_flash_resume_wel_sector_protect_props (.aclk, .aresetn,
    .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
    .protect_regs_locked_flag, .pe_req, .pe_addr, .pe_grant, .pe_deny,
    .resume_prog, .resume_erase, .suspend_prog, .suspend_erase,
    .write_latch_flag, .program_paused_flag, .ready_busy_flag,
    .sector_write_guard_bit);

  always #25 aclk = ~aclk;

  task automatic conclude();
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rst();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : rst

  task automatic wr(input logic [31:0] a, d);
    logic ad = 1'b0;
    logic wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic send(input logic [7:0] op, input logic [2:0] nb, xb,
    input logic [23:0] ad);
    wr(32'(REG_ADDR), {8'h00, ad});
    wr(32'(REG_CMD), {17'h0, xb, 1'b0, nb, op});
    // Device has acted by the time the host reports idle
    do rd(32'(REG_STATUS)); while (v[STAT_BUSY_BIT] !== 1'b0);
  endtask : send

  task automatic pe(input logic [23:0] a, input logic e, input logic [1:0] x);
    @(posedge aclk);
    pe_req <= 1'b1;
    pe_addr <= a;
    pe_is_erase <= e;
    @(posedge aclk);
    pe_req <= 1'b0;
    @(posedge aclk);
    chk("grant_deny", {pe_grant, pe_deny}, x);
  endtask : pe

  task automatic flags(input logic [2:0] e);
    // Busy follows an engine input one edge late
    repeat (2) @(posedge aclk);
    chk("paused_busy", {program_paused_flag, erase_paused_flag,
      ready_busy_flag}, e);
  endtask : flags

  initial begin
    rst();
    chk("guard", sector_write_guard_bit, 16'hFFFF);
    foreach (rows[i]) begin
      protect_regs_locked_flag <= rows[i].lk;
      send(rows[i].op, rows[i].nb, rows[i].xb, rows[i].ad);
      chk("latch", write_latch_flag, rows[i].wl);
      chk("guard", sector_write_guard_bit, rows[i].g);
    end
    protect_regs_locked_flag <= 1'b0;
    pe(24'h050000, 1'b0, 2'h1);
    send(OP_WREN, 3'h1, 3'h0, 24'h0);
    pe(24'h05FFFF, 1'b0, 2'h2);
    chk("latch", write_latch_flag, 1'b0);
    send(OP_WREN, 3'h1, 3'h0, 24'h0);
    pe(24'h000000, 1'b1, 2'h1);
    erase_running <= 1'b1;
    send(OP_SUSPEND, 3'h1, 3'h0, 24'h0);
    erase_running <= 1'b0;
    prog_running <= 1'b1;
    send(OP_SUSPEND, 3'h1, 3'h0, 24'h0);
    prog_running <= 1'b0;
    flags(3'h6);
    send(OP_RESUME, 3'h1, 3'h3, 24'h0);
    flags(3'h6);
    send(OP_RESUME, 3'h2, 3'h0, 24'h0);
    flags(3'h3);
    prog_running <= 1'b1;
    send(OP_SUSPEND, 3'h1, 3'h0, 24'h0);
    flags(3'h3);
    prog_running <= 1'b0;
    repeat (400) @(posedge aclk);
    flags(3'h2);
    send(OP_RESUME, 3'h1, 3'h0, 24'h0);
    flags(3'h1);
    wr(32'h0000000C, 32'h0);
    chk("bresp", r, AXI_SLVERR);
    rd(32'h0000000C);
    chk("rresp", r, AXI_SLVERR);
    rst();
    chk("guard", sector_write_guard_bit, 16'hFFFF);
    conclude();
  end
endmodule : flash_resume_wel_sector_protect_test
